// >>> hdl/stm_consts.vh
`ifndef STM_CONSTS_VH
`define STM_CONSTS_VH
`define STM_ADDR_CNT_LO   4'h0
`define STM_ADDR_CNT_HI   4'h1
`define STM_ADDR_CMPA_LO  4'h2
`define STM_ADDR_CMPA_HI  4'h3
`define STM_ADDR_CMPP     4'h4
`define STM_ADDR_CTRL     4'h5
`define STM_ADDR_STAT     4'h6
`define STM_ADDR_PRESC    4'h7
`define STM_CTRL_CLR      0
`define STM_CTRL_SWAP     1
`define STM_CTRL_INV      2
`define STM_CTRL_INIT     3
`define STM_CTRL_ACT_LO   4
`define STM_CTRL_MODE_LO  6
`define STM_CTRL_RUN      8
`define STM_STAT_AF       0
`define STM_STAT_PF       1
`define STM_MODE_CMP      2'h0
`define STM_MODE_PWM      2'h2
`define STM_MODE_TMR      2'h3
`define STM_ACT_NONE      2'h0
`define STM_ACT_LOW       2'h1
`define STM_ACT_HIGH      2'h2
`define STM_ACT_TOG       2'h3
`define STM_RESP_OKAY     2'h0
`define STM_RESP_SLVERR   2'h2
`endif

// >>> hdl/stm_timer.v
`include "stm_consts.vh"

module stm_timer (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        clk_en,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         timer_pin_out,
  output reg         timer_pin_oe,
  output wire        match_a_flag,
  output wire        match_p_flag
);

  reg  [15:0] count_r;
  reg  [15:0] cmpa_r;
  reg  [7:0]  cmpp_r;
  reg  [8:0]  ctrl_r;
  reg  [7:0]  presc_r;
  reg  [7:0]  div_r;
  reg         af_r;
  reg         pf_r;
  reg         run_d_r;
  reg         pin_r;
  reg         aw_hold_r;
  reg  [3:0]  aw_idx_r;
  reg         w_hold_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;

  wire        clr_sel  = ctrl_r[`STM_CTRL_CLR];
  wire        swap     = ctrl_r[`STM_CTRL_SWAP];
  wire        invert   = ctrl_r[`STM_CTRL_INV];
  wire        init_lvl = ctrl_r[`STM_CTRL_INIT];
  wire [1:0]  act      = ctrl_r[`STM_CTRL_ACT_LO+1:`STM_CTRL_ACT_LO];
  wire [1:0]  mode     = ctrl_r[`STM_CTRL_MODE_LO+1:`STM_CTRL_MODE_LO];
  wire        run      = ctrl_r[`STM_CTRL_RUN];

  // Prescaler models the selectable timer clock as a tick enable
  wire        tick     = run && run_d_r && (div_r == presc_r);
  wire        run_rise = run && !run_d_r;
  wire        is_pwm   = (mode == `STM_MODE_PWM);
  wire        is_cmp   = (mode == `STM_MODE_CMP);
  wire        is_tmr   = (mode == `STM_MODE_TMR);

  wire [15:0] cnt_inc  = count_r + 16'h0001;
  // Match is judged on the count about to be reached
  wire        a_hit    = (cnt_inc == cmpa_r);
  wire        ovf      = (count_r == 16'hFFFF);
  wire        p_hit    = (cmpp_r == 8'h00) ? ovf :
                         ((cnt_inc[15:8] == cmpp_r) &&
                          (cnt_inc[7:0] == 8'h00));

  // Period and duty roles in PWM
  wire        per_end  = swap ? a_hit : p_hit;
  wire [16:0] per_len  = swap ? {1'b0, cmpa_r} :
                         ((cmpp_r == 8'h00) ? 17'h10000 :
                          {1'b0, cmpp_r, 8'h00});
  wire [16:0] duty_len = swap ?
                         ((cmpp_r == 8'h00) ? 17'h10000 :
                          {1'b0, cmpp_r, 8'h00}) :
                         {1'b0, cmpa_r};
  wire        full     = (duty_len >= per_len);
  wire        active   = full || ({1'b0, count_r} < duty_len);

  // Counter clear source
  reg         clr_now;
  always @* begin
    if (is_pwm) begin
      clr_now = per_end;
    end else if (clr_sel) begin
      clr_now = a_hit;
    end else begin
      clr_now = p_hit;
    end
  end

  wire        set_af   = tick && a_hit;
  wire        set_pf   = tick && p_hit &&
                         (is_pwm || !clr_sel);

  // AXI4-Lite slave: single outstanding write and read
  // Ready drops with the enable, so no AW, W or AR handshake is lost while frozen
  assign s_axi_awready = clk_en && !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready  = clk_en && !w_hold_r && !s_axi_bvalid;
  assign s_axi_arready = clk_en && !s_axi_rvalid;

  wire        aw_ok    = aw_hold_r || (s_axi_awvalid && s_axi_awready);
  wire        w_ok     = w_hold_r || (s_axi_wvalid && s_axi_wready);
  wire [3:0]  aw_idx   = aw_hold_r ? aw_idx_r : s_axi_awaddr[5:2];
  wire [31:0] wd       = w_hold_r ? w_data_r : s_axi_wdata;
  wire [3:0]  ws       = w_hold_r ? w_strb_r : s_axi_wstrb;
  wire        do_wr    = aw_ok && w_ok && !s_axi_bvalid;
  wire        wr_ok    = (aw_idx <= `STM_ADDR_PRESC) &&
                         (aw_idx != `STM_ADDR_CNT_LO) &&
                         (aw_idx != `STM_ADDR_CNT_HI);
  wire        wr_stat  = do_wr && ws[0] && (aw_idx == `STM_ADDR_STAT);

  reg  [31:0] rd_val;
  reg         rd_ok;
  always @* begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    case (s_axi_araddr[5:2])
      `STM_ADDR_CNT_LO:  rd_val[7:0] = count_r[7:0];
      `STM_ADDR_CNT_HI:  rd_val[7:0] = count_r[15:8];
      `STM_ADDR_CMPA_LO: rd_val[7:0] = cmpa_r[7:0];
      `STM_ADDR_CMPA_HI: rd_val[7:0] = cmpa_r[15:8];
      `STM_ADDR_CMPP:    rd_val[7:0] = cmpp_r;
      `STM_ADDR_CTRL:    rd_val[8:0] = ctrl_r;
      `STM_ADDR_STAT:    rd_val[1:0] = {pf_r, af_r};
      `STM_ADDR_PRESC:   rd_val[7:0] = presc_r;
      default:           rd_ok = 1'b0;
    endcase
    if (s_axi_araddr[31:6] != 26'h0) begin
      rd_ok = 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      count_r      <= 16'h0000;
      cmpa_r       <= 16'h0000;
      cmpp_r       <= 8'h00;
      ctrl_r       <= 9'h000;
      presc_r      <= 8'h00;
      div_r        <= 8'h00;
      af_r         <= 1'b0;
      pf_r         <= 1'b0;
      run_d_r      <= 1'b0;
      pin_r        <= 1'b0;
      aw_hold_r    <= 1'b0;
      aw_idx_r     <= 4'h0;
      w_hold_r     <= 1'b0;
      w_data_r     <= 32'h0000_0000;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `STM_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `STM_RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      timer_pin_out <= 1'b0;
      timer_pin_oe  <= 1'b0;
    end else if (clk_en) begin
      run_d_r <= run;
      if (!run || div_r == presc_r) begin
        div_r <= 8'h00;
      end else begin
        div_r <= div_r + 8'h01;
      end

      // Counter
      if (run_rise) begin
        count_r <= 16'h0000;
      end else if (tick) begin
        count_r <= clr_now ? 16'h0000 : cnt_inc;
      end

      // Sticky flags; a new event beats a software clear
      if (set_af) begin
        af_r <= 1'b1;
      end else if (wr_stat && wd[`STM_STAT_AF]) begin
        af_r <= 1'b0;
      end
      if (set_pf) begin
        pf_r <= 1'b1;
      end else if (wr_stat && wd[`STM_STAT_PF]) begin
        pf_r <= 1'b0;
      end

      // Compare-mode output latch
      if (run_rise) begin
        pin_r <= init_lvl;
      end else if (set_af && is_cmp) begin
        case (act)
          `STM_ACT_LOW:  pin_r <= 1'b0;
          `STM_ACT_HIGH: pin_r <= 1'b1;
          `STM_ACT_TOG:  pin_r <= ~pin_r;
          default:       pin_r <= pin_r;
        endcase
      end

      // Pin drive
      timer_pin_oe <= !is_tmr && (mode != 2'h1);
      if (is_pwm) begin
        case (act)
          `STM_ACT_NONE: timer_pin_out <= invert ^ ~init_lvl;
          `STM_ACT_LOW:  timer_pin_out <= invert ^ init_lvl;
          `STM_ACT_HIGH: timer_pin_out <=
                           invert ^ (active && run ? init_lvl : ~init_lvl);
          default:       timer_pin_out <= invert ^ ~init_lvl;
        endcase
      end else if (is_cmp) begin
        timer_pin_out <= pin_r ^ invert;
      end else begin
        timer_pin_out <= 1'b0;
      end

      // Write path
      if (s_axi_awvalid && s_axi_awready && !do_wr) begin
        aw_hold_r <= 1'b1;
        aw_idx_r  <= s_axi_awaddr[5:2];
      end
      if (s_axi_wvalid && s_axi_wready && !do_wr) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `STM_RESP_OKAY : `STM_RESP_SLVERR;
        if (ws[0]) begin
          case (aw_idx)
            `STM_ADDR_CMPA_LO: cmpa_r[7:0]  <= wd[7:0];
            `STM_ADDR_CMPA_HI: cmpa_r[15:8] <= wd[7:0];
            `STM_ADDR_CMPP:    cmpp_r       <= wd[7:0];
            `STM_ADDR_CTRL:    ctrl_r[7:0]  <= wd[7:0];
            `STM_ADDR_PRESC:   presc_r      <= wd[7:0];
            default:           ctrl_r[7:0]  <= ctrl_r[7:0];
          endcase
        end
        if (ws[1] && aw_idx == `STM_ADDR_CTRL) begin
          ctrl_r[8] <= wd[8];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end

      // Read path
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_ok ? rd_val : 32'h0000_0000;
        s_axi_rresp  <= rd_ok ? `STM_RESP_OKAY : `STM_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  assign match_a_flag = af_r;
  assign match_p_flag = pf_r;

endmodule

// >>> verif/stm_timer_sva.sv
module stm_timer_sva (
  input logic        aclk,
  input logic        aresetn,
  input logic        clk_en,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic        timer_pin_out,
  input logic        timer_pin_oe,
  input logic        match_a_flag,
  input logic        match_p_flag
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Only a status write may drop a flag
  AST_AF_STICKY: assert property ($fell(match_a_flag) |-> s_axi_bvalid)
    else $error("match_a_flag fell without a write");
  AST_PF_STICKY: assert property ($fell(match_p_flag) |-> s_axi_bvalid)
    else $error("match_p_flag fell without a write");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer moved");
  AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while answer pending");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  AST_B_ANSWER: assert property (clk_en && s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> s_axi_bvalid) else $error("no bvalid");
  AST_R_ANSWER: assert property (clk_en && s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("no rvalid");
  // Reset itself must be seen, so no disable here
  AST_RESET: assert property (disable iff (1'b0) !aresetn |=>
    !s_axi_bvalid && !s_axi_rvalid && !match_a_flag && !match_p_flag &&
    !timer_pin_oe && !timer_pin_out) else $error("state after reset");
  COV_PIN: cover property ($rose(timer_pin_out));
  COV_PF: cover property ($rose(match_p_flag));
  COV_CLR: cover property ($fell(match_a_flag));
endmodule

bind stm_timer stm_timer_sva u_sva (.aclk, .aresetn, .clk_en,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .timer_pin_out,
  .timer_pin_oe, .match_a_flag, .match_p_flag);

// >>> verif/tb_top.sv
`include "stm_consts.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
  logic [31:0] s_axi_araddr = 32'h0, d;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  r;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire         s_axi_rvalid, timer_pin_out, timer_pin_oe;
  wire         match_a_flag, match_p_flag;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  int          err_count = 0, samples_checked = 0;
  stm_timer u_dut (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .timer_pin_out, .timer_pin_oe,
    .match_a_flag, .match_p_flag);
  always #10 aclk = ~aclk;
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic hang;
    err_count++;
    tally_and_finish();
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v,
                    output logic [1:0] rs);
    bit pb;
    int n;
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= {16'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    pb = 1;
    for (n = 0; pb && n < 99; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid) begin
        rs = s_axi_bresp;
        pb = 0;
        s_axi_bready <= 1'b0;
      end
    end
    if (pb)
      hang();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] dv,
                    output logic [1:0] rs);
    bit pr;
    int n;
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    pr = 1;
    for (n = 0; pr && n < 99; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        dv = s_axi_rdata;
        rs = s_axi_rresp;
        pr = 0;
        s_axi_rready <= 1'b0;
      end
    end
    if (pr)
      hang();
  endtask
  task automatic wflag(input bit p);
    int n;
    for (n = 0; n < 2000; n++) begin
      @(posedge aclk);
      if ((p ? match_p_flag : match_a_flag) === 1'b1)
        return;
    end
    hang();
  endtask
  // Stop first: mode and action changes while running are unsafe
  task automatic cfg(input logic [15:0] c, input logic [15:0] a,
                     input logic [7:0] p);
    wr(8'h14, c, r);
    wr(8'h08, {8'h0, a[7:0]}, r);
    wr(8'h0C, {8'h0, a[15:8]}, r);
    wr(8'h10, {8'h0, p}, r);
    wr(8'h18, 16'h0003, r);
    wr(8'h14, c | 16'h0100, r);
  endtask
  task automatic t_regs;
    for (int i = 0; i < 5; i++) begin
      rd(8'(i * 4), d, r);
      chk(d, 32'h0);
    end
    wr(8'h00, 16'h0055, r);
    chk(r, `STM_RESP_SLVERR);
    rd(8'h20, d, r);
    chk(r, `STM_RESP_SLVERR);
    chk(d, 32'h0);
    wr(8'h0C, 16'h00A5, r);
    rd(8'h0C, d, r);
    chk(d, 32'hA5);
  endtask
  // A clears at 0x200, so a P match at 0x100 would be visible
  task automatic t_cmp_a;
    cfg(16'h0031, 16'h0200, 8'h01);
    wflag(0);
    rd(8'h04, d, r);
    chk(d < 2, 1'b1);
    chk(match_p_flag, 1'b0);
    chk(timer_pin_out, 1'b1);
    wr(8'h18, 16'h0003, r);
    chk(match_a_flag, 1'b0);
    clk_en <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(s_axi_awready, 1'b0);
    chk(s_axi_arready, 1'b0);
    clk_en <= 1'b1;
    @(posedge aclk);
  endtask
  task automatic t_cmp_p;
    cfg(16'h0020, 16'h0080, 8'h01);
    rd(8'h18, d, r);
    chk(timer_pin_out, 1'b0);
    wflag(1);
    chk(match_a_flag, 1'b1);
    chk(timer_pin_out, 1'b1);
    rd(8'h04, d, r);
    chk(d, 32'h0);
    cfg(16'h00E0, 16'h0080, 8'h01);
    wflag(1);
    chk(timer_pin_oe, 1'b0);
    chk(match_a_flag, 1'b1);
  endtask
  localparam logic [15:0] PC [0:7] = '{16'h00A8, 16'h00AC, 16'h00A8,
    16'h00AA, 16'h0098, 16'h0088, 16'h00A0, 16'h00A9};
  localparam logic [15:0] PA [0:7] = '{16'h0040, 16'h0040, 16'h0200,
    16'h0200, 16'h0040, 16'h0040, 16'h0040, 16'h0040};
  localparam int PH [0:7] = '{128, 384, 512, 256, 512, 0, 384, 128};
  // Any 512-cycle window holds two whole periods of 256, or one whole period of 512 when swapped
  task automatic t_pwm;
    int h;
    for (int i = 0; i < 8; i++) begin
      cfg(PC[i], PA[i], 8'h01);
      repeat (600) @(posedge aclk);
      h = 0;
      repeat (512) begin
        @(posedge aclk);
        h += int'(timer_pin_out === 1'b1);
      end
      chk(h, PH[i]);
      chk(match_p_flag, 1'b1);
    end
    chk(match_a_flag, 1'b1);
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_cmp_a();
    t_cmp_p();
    t_pwm();
    tally_and_finish();
  end
endmodule
